// ===== rtl/eid_pkg.sv
package eid_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] EID_ADDR_SRC = 8'h00;
   localparam logic [7:0] EID_ADDR_PPR = 8'h04;
   localparam logic [7:0] EID_ADDR_TYPE = 8'h08;
   localparam logic [7:0] EID_ADDR_DIV = 8'h0C;
   localparam logic [7:0] EID_ADDR_POS = 8'h10;
   localparam logic [7:0] EID_ADDR_SPEED = 8'h14;
   localparam logic [7:0] EID_ADDR_STATUS = 8'h18;
   localparam logic [7:0] EID_ADDR_GATE = 8'h1C;

   // ------------------------------------------------------------
   // widths, limits and reset values
   // ------------------------------------------------------------
   localparam int EID_PPR_W = 15;
   localparam int EID_DIV_W = 8;
   localparam int EID_POS_W = 32;
   localparam int EID_SRC_W = 3;
   localparam int EID_TYPE_W = 3;
   localparam logic [EID_PPR_W-1:0] EID_PPR_MIN = 15'h0001;
   localparam logic [EID_PPR_W-1:0] EID_PPR_MAX = 15'h4E20;
   localparam logic [EID_PPR_W-1:0] EID_PPR_RST = 15'h0258;
   localparam logic [EID_DIV_W-1:0] EID_DIV_MIN = 8'h01;
   localparam logic [EID_DIV_W-1:0] EID_DIV_RST = 8'h01;
   localparam logic [31:0] EID_GATE_RST = 32'h0003_D090;

   // ------------------------------------------------------------
   // feedback source codes
   // ------------------------------------------------------------
   typedef enum logic [EID_SRC_W-1:0] {
      EID_SRC_OFF = 3'h0,
      EID_SRC_QUAD_INDEX = 3'h1,
      EID_SRC_QUAD_INDEX_ALT = 3'h2,
      EID_SRC_RESOLVER = 3'h3,
      EID_SRC_QUAD_COMMUTATION = 3'h4,
      EID_SRC_PULSE_TERMINAL = 3'h5
   } eid_src_e;

   // ------------------------------------------------------------
   // input type codes
   // ------------------------------------------------------------
   typedef enum logic [EID_TYPE_W-1:0] {
      EID_TYPE_OFF = 3'h0,
      EID_TYPE_QUAD_A_FWD = 3'h1,
      EID_TYPE_QUAD_B_FWD = 3'h2,
      EID_TYPE_PULSE_BHI_FWD = 3'h3,
      EID_TYPE_PULSE_BLO_FWD = 3'h4
   } eid_type_e;

   // ------------------------------------------------------------
   // status bit positions
   // ------------------------------------------------------------
   localparam int EID_ST_DIR = 0;
   localparam int EID_ST_ACTIVE = 1;
   localparam int EID_ST_ERR = 2;

   // ------------------------------------------------------------
   // bus carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } eid_wb_req_s;

   typedef struct packed {
      logic a;
      logic b;
   } eid_phase_s;

endpackage : eid_pkg

// ===== rtl/eid_decoder.sv
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - type 1: A leads means forward
// - type 2: B leads means forward
// - type 3: A pulses, B high forward
// - type 4: A pulses, B low forward; 0 off
// - source codes 0 to 5 as listed
// - pulses per rev 1..20000, default 600
// - divider denominator defaults to 1
// - divided output: count over denominator 1..255
module eid_decoder
   import eid_pkg::*;
#(
   parameter int POS_W = EID_POS_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire eid_wb_req_s wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // feedback phases
   input wire eid_phase_s phase_i,
   // decoded outputs
   output logic step_o,
   output logic dir_fwd_o,
   output logic div_pulse_o
);

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   eid_src_e src;
   eid_type_e in_type;
   logic [EID_PPR_W-1:0] ppr;
   logic [EID_DIV_W-1:0] div_den;
   logic [31:0] gate_len;
   logic cfg_err;

   logic wr_go;
   logic rd_go;
   assign wr_go = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~wb_ack_o;
   assign rd_go = wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src <= EID_SRC_OFF;
         in_type <= EID_TYPE_OFF;
         ppr <= EID_PPR_RST;
         div_den <= EID_DIV_RST;
         gate_len <= EID_GATE_RST;
      end else if (wr_go && wb_req_i.sel[0]) begin
         case (wb_req_i.adr)
            EID_ADDR_SRC: begin
               // unknown codes are refused and keep the old source
               if (wb_req_i.dat[EID_SRC_W-1:0] <= EID_SRC_PULSE_TERMINAL) begin
                  src <= eid_src_e'(wb_req_i.dat[EID_SRC_W-1:0]);
               end
            end
            EID_ADDR_TYPE: begin
               if (wb_req_i.dat[EID_TYPE_W-1:0] <= EID_TYPE_PULSE_BLO_FWD) begin
                  in_type <= eid_type_e'(wb_req_i.dat[EID_TYPE_W-1:0]);
               end
            end
            EID_ADDR_PPR: begin
               if (wb_req_i.sel[1] && wb_req_i.dat[EID_PPR_W-1:0] >= EID_PPR_MIN
                   && wb_req_i.dat[EID_PPR_W-1:0] <= EID_PPR_MAX
                   && wb_req_i.dat[15] == 1'b0) begin
                  ppr <= wb_req_i.dat[EID_PPR_W-1:0];
               end
            end
            EID_ADDR_DIV: begin
               // zero would give a divided pulse on every step, so it is refused
               if (wb_req_i.dat[EID_DIV_W-1:0] >= EID_DIV_MIN) begin
                  div_den <= wb_req_i.dat[EID_DIV_W-1:0];
               end
            end
            EID_ADDR_GATE: begin
               if (&wb_req_i.sel) begin
                  gate_len <= wb_req_i.dat;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // phase synchroniser
   // ------------------------------------------------------------
   eid_phase_s sync1;
   eid_phase_s sync2;
   eid_phase_s prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
      end else begin
         sync1 <= phase_i;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   // ------------------------------------------------------------
   // direction and step decode
   // ------------------------------------------------------------
   logic next_step;
   logic next_fwd;
   logic next_err;
   logic quad_a_lead;
   logic a_edge;
   logic b_edge;
   logic [1:0] settle;

   // the synchroniser starts at zero, so a pin that idles high would
   // look like an edge right after reset; decoding waits until the
   // pipeline has filled with real pin levels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         settle <= '0;
      end else if (!(&settle)) begin
         settle <= settle + 2'b01;
      end
   end

   assign a_edge = sync2.a ^ prev.a;
   assign b_edge = sync2.b ^ prev.b;
   // A leads when the new A level differs from the old B level
   assign quad_a_lead = sync2.a ^ prev.b;

   always_comb begin
      next_step = 1'b0;
      next_fwd = dir_fwd_o;
      next_err = 1'b0;
      if (src != EID_SRC_OFF && (&settle)) begin
         case (in_type)
            EID_TYPE_QUAD_A_FWD, EID_TYPE_QUAD_B_FWD: begin
               if (a_edge && b_edge) begin
                  // both moved in one sample: order unknown, count nothing
                  next_err = 1'b1;
               end else if (a_edge || b_edge) begin
                  next_step = 1'b1;
                  if (in_type == EID_TYPE_QUAD_A_FWD) begin
                     next_fwd = (a_edge & (sync2.a != sync2.b))
                                | (b_edge & (sync2.a == sync2.b));
                  end else begin
                     next_fwd = (b_edge & (sync2.a != sync2.b))
                                | (a_edge & (sync2.a == sync2.b));
                  end
               end
            end
            EID_TYPE_PULSE_BHI_FWD: begin
               if (sync2.a && !prev.a) begin
                  next_step = 1'b1;
                  next_fwd = sync2.b;
               end
            end
            EID_TYPE_PULSE_BLO_FWD: begin
               if (sync2.a && !prev.a) begin
                  next_step = 1'b1;
                  next_fwd = ~sync2.b;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_o <= 1'b0;
         dir_fwd_o <= 1'b1;
      end else begin
         step_o <= next_step;
         dir_fwd_o <= next_fwd;
      end
   end

   // ------------------------------------------------------------
   // position counter and error flag
   // ------------------------------------------------------------
   logic [POS_W-1:0] pos;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos <= '0;
      end else if (next_step) begin
         pos <= next_fwd ? pos + 1'b1 : pos - 1'b1;
      end
   end

   // sticky; a new error in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_err <= 1'b0;
      end else if (next_err) begin
         cfg_err <= 1'b1;
      end else if (wr_go && wb_req_i.adr == EID_ADDR_STATUS && wb_req_i.dat[EID_ST_ERR]) begin
         cfg_err <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // speed: steps per gate, scaled by pulses per rev in software
   // ------------------------------------------------------------
   logic [31:0] gate_cnt;
   logic [31:0] step_acc;
   logic [31:0] speed;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_cnt <= '0;
         step_acc <= '0;
         speed <= '0;
      end else if (gate_cnt >= gate_len) begin
         gate_cnt <= '0;
         step_acc <= '0;
         speed <= step_acc;
      end else begin
         gate_cnt <= gate_cnt + 32'h0000_0001;
         step_acc <= step_acc + {31'h0000_0000, next_step};
      end
   end

   // ------------------------------------------------------------
   // divided pulse output
   // ------------------------------------------------------------
   logic [EID_DIV_W-1:0] div_cnt;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= '0;
         div_pulse_o <= 1'b0;
      end else begin
         div_pulse_o <= 1'b0;
         if (next_step) begin
            if (div_cnt + 1'b1 >= div_den) begin
               div_cnt <= '0;
               div_pulse_o <= 1'b1;
            end else begin
               div_cnt <= div_cnt + 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [31:0] next_rd;

   always_comb begin
      next_rd = '0;
      case (wb_req_i.adr)
         EID_ADDR_SRC: next_rd = {29'h0000_0000, src};
         EID_ADDR_PPR: next_rd = {17'h0_0000, ppr};
         EID_ADDR_TYPE: next_rd = {29'h0000_0000, in_type};
         EID_ADDR_DIV: next_rd = {24'h00_0000, div_den};
         EID_ADDR_POS: next_rd = 32'(pos);
         EID_ADDR_SPEED: next_rd = speed;
         EID_ADDR_STATUS: begin
            next_rd[EID_ST_DIR] = dir_fwd_o;
            next_rd[EID_ST_ACTIVE] = (src != EID_SRC_OFF) && (in_type != EID_TYPE_OFF);
            next_rd[EID_ST_ERR] = cfg_err;
         end
         EID_ADDR_GATE: next_rd = gate_len;
         default: next_rd = '0;
      endcase
   end

   // one wait state; unmapped reads answer zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
         wb_dat_o <= rd_go ? next_rd : '0;
      end
   end

endmodule : eid_decoder

`default_nettype wire

// ===== test/eid_decoder_checker.sv
`timescale 1ns/10ps
`default_nettype none
module eid_decoder_checker
   import eid_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // watched ports
   input wire eid_wb_req_s wb_req_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire eid_phase_s phase_i,
   input wire logic step_o,
   input wire logic dir_fwd_o,
   input wire logic div_pulse_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_follows:
   assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   chk_ack_single:
   assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   chk_ack_cause:
   assert property (wb_ack_o |-> $past(wb_req_i.cyc) && $past(wb_req_i.stb))
      else $error("ack without request");
   chk_data_idle:
   assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   chk_step_single:
   assert property (step_o |=> !step_o)
      else $error("step too long");
   chk_step_cause:
   assert property (step_o |-> $past(phase_i, 2) != $past(phase_i, 5))
      else $error("step without phase edge");
   chk_dir_cause:
   assert property ($changed(dir_fwd_o) |-> step_o)
      else $error("direction moved without step");
   chk_div_cause:
   assert property (div_pulse_o |-> step_o || $past(step_o))
      else $error("divided pulse without step");
endmodule : eid_decoder_checker
bind eid_decoder eid_decoder_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_i(phase_i),
   .step_o(step_o), .dir_fwd_o(dir_fwd_o), .div_pulse_o(div_pulse_o));
`default_nettype wire

// ===== test/eid_enc_model.sv
`timescale 1ns/10ps
`default_nettype none
module eid_enc_model
   import eid_pkg::*;
(
   input wire logic clk_i,
   output var eid_phase_s phase_o
);
   initial phase_o = '0;
   // one phase moves per edge, held 4 cycles
   task automatic quad(input logic a_lead);
      eid_phase_s p;
      p = phase_o;
      @(posedge clk_i);
      if ((p.a == p.b) == a_lead) phase_o.a <= !p.a;
      else phase_o.b <= !p.b;
      repeat (4) @(posedge clk_i);
   endtask : quad
   // direction settles before the pulse rises
   task automatic pulse(input logic lev);
      @(posedge clk_i);
      phase_o.a <= 1'b0;
      repeat (4) @(posedge clk_i);
      phase_o.b <= lev;
      repeat (4) @(posedge clk_i);
      phase_o.a <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask : pulse
endmodule : eid_enc_model
`default_nettype wire

// ===== test/eid_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module eid_decoder_tb
   import eid_pkg::*;
;
   logic clk_i = 0;
   logic rst_i = 1;
   eid_wb_req_s req = '0;
   eid_phase_s phase;
   logic [31:0] rdat;
   logic ack, step, dir_fwd, div_pulse;
   int num_errors = 0, comparisons = 0, cycles = 0, nsteps = 0, ndiv = 0;
   eid_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat),
      .wb_ack_o(ack), .phase_i(phase), .step_o(step), .dir_fwd_o(dir_fwd),
      .div_pulse_o(div_pulse));
   eid_enc_model enc (.clk_i(clk_i), .phase_o(phase));
   initial forever #12.5 clk_i = !clk_i;
   always @(posedge clk_i) begin
      nsteps += (step === 1'b1);
      ndiv += (div_pulse === 1'b1);
      cycles++;
      if (cycles == 8000) begin
         num_errors++;
         end_of_test();
      end
   end
   // ----------------
   // helpers
   // ----------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // wait for ack without assuming latency
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      req <= '0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q, e);
   endtask : rchk
   task automatic run(input int ty, input logic pm, input logic lev, input int n,
      input int en, input logic ed);
      int s0;
      wr(EID_ADDR_TYPE, 32'(ty));
      s0 = nsteps;
      repeat (n) if (pm) enc.pulse(lev); else enc.quad(lev);
      repeat (6) @(posedge clk_i);
      chk(32'(nsteps - s0), 32'(en));
      if (en > 0) chk({31'h0, dir_fwd}, {31'h0, ed});
   endtask : run
   // ----------------
   // scenarios
   // ----------------
   task automatic t_regs();
      rchk(EID_ADDR_PPR, 32'h0000_0258);
      rchk(EID_ADDR_DIV, 32'h0000_0001);
      rchk(EID_ADDR_TYPE, 32'h0000_0000);
      wr(EID_ADDR_PPR, 32'h0000_0000);
      rchk(EID_ADDR_PPR, 32'h0000_0258);
      wr(EID_ADDR_PPR, 32'h0000_4E21);
      rchk(EID_ADDR_PPR, 32'h0000_0258);
      wr(EID_ADDR_PPR, 32'h0000_4E20);
      rchk(EID_ADDR_PPR, 32'h0000_4E20);
      for (int i = 0; i < 7; i++) begin
         wr(EID_ADDR_SRC, 32'(i));
         rchk(EID_ADDR_SRC, 32'((i < 6) ? i : 5));
      end
      rchk(8'h20, 32'h0000_0000);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_quad();
      wr(EID_ADDR_SRC, 32'h0000_0001);
      run(1, 0, 1, 4, 4, 1);
      run(1, 0, 0, 4, 4, 0);
      run(2, 0, 1, 4, 4, 0);
      run(2, 0, 0, 4, 4, 1);
      $display("t_quad done");
   endtask : t_quad
   task automatic t_pulse();
      run(3, 1, 1, 3, 3, 1);
      run(3, 1, 0, 3, 3, 0);
      run(4, 1, 1, 3, 3, 0);
      run(4, 1, 0, 2, 2, 1);
      run(0, 1, 1, 2, 0, 0);
      wr(EID_ADDR_SRC, 32'h0000_0000);
      run(3, 1, 0, 2, 0, 0);
      $display("t_pulse done");
   endtask : t_pulse
   task automatic t_div();
      int d0;
      chk(32'(ndiv), 32'(nsteps));
      wr(EID_ADDR_SRC, 32'h0000_0001);
      wr(EID_ADDR_DIV, 32'h0000_0003);
      wr(EID_ADDR_DIV, 32'h0000_0000);
      rchk(EID_ADDR_DIV, 32'h0000_0003);
      d0 = ndiv;
      run(3, 1, 1, 6, 6, 1);
      chk(32'(ndiv - d0), 32'h0000_0002);
      wr(EID_ADDR_DIV, 32'h0000_00FF);
      rchk(EID_ADDR_DIV, 32'h0000_00FF);
      rchk(EID_ADDR_POS, 32'h0000_0005);
      rchk(EID_ADDR_STATUS, 32'h0000_0003);
      wr(EID_ADDR_SRC, 32'h0000_0003);
      wr(EID_ADDR_PPR, 32'h0000_0400);
      rchk(EID_ADDR_PPR, 32'h0000_0400);
      wr(EID_ADDR_SRC, 32'h0000_0005);
      rchk(EID_ADDR_SRC, 32'h0000_0005);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rchk(EID_ADDR_PPR, 32'h0000_0258);
      rchk(EID_ADDR_SRC, 32'h0000_0000);
      rchk(EID_ADDR_DIV, 32'h0000_0001);
      $display("t_div done");
   endtask : t_div
   task automatic end_of_test();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_quad();
      t_pulse();
      t_div();
      end_of_test();
   end
endmodule : eid_decoder_tb
`default_nettype wire
